// >>> rtl/modem_host_pkg.sv
package modem_host_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] TX_W0_OFS     = 8'h00B5;
    localparam logic [7:0] TX_W1_OFS     = 8'h00B6;
    localparam logic [7:0] TX_W2_OFS     = 8'h00B7;
    localparam logic [7:0] TX_W3_OFS     = 8'h00CA;
    localparam logic [7:0] TX_W4_OFS     = 8'h00CB;
    localparam logic [7:0] RX_W0_OFS     = 8'h00B8;
    localparam logic [7:0] RX_W1_OFS     = 8'h00B9;
    localparam logic [7:0] RX_W2_OFS     = 8'h00BA;
    localparam logic [7:0] RX_W3_OFS     = 8'h00BB;
    localparam logic [7:0] RX_W4_OFS     = 8'h00C5;
    localparam logic [7:0] MODE_OFS      = 8'h00C1;
    localparam logic [7:0] STATUS_OFS    = 8'h00C6;
    localparam logic [7:0] PROG_ADDR_OFS = 8'h00C7;
    localparam logic [7:0] PROG_DATA_OFS = 8'h00C8;
    localparam logic [7:0] MODEM_ST_OFS  = 8'h00C9;
    // ==========================================
    // Fields and reset values
    localparam int unsigned TCNT_LSB     = 6;
    localparam int unsigned BLK_ID_LSB   = 4;
    localparam int unsigned ST_EVENT_BIT = 14;
    localparam int unsigned ST_READY_BIT = 6;
    localparam int unsigned ST_PFLAG_BIT = 0;
    localparam int unsigned PT_RD_BIT    = 15;
    localparam int unsigned PT_WIDE_BIT  = 14;
    localparam int unsigned PT_SEL_BIT   = 13;
    localparam int unsigned PT_RSV_BIT   = 12;
    localparam logic [3:0]  PT_MARK      = 4'h000F;
    localparam logic [15:0] MODE_RESET   = 16'h0000;
    localparam logic [3:0]  MODE_PSAVE   = 4'h0009;
    localparam logic [1:0]  VAR_ENH_E    = 2'h2;
    localparam int unsigned OPT_DYN_LP   = 0;
    localparam int unsigned OPT_SINGLE   = 1;
    localparam int unsigned READ_WORDS   = 7;
    // ==========================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned REMOTE_HALF_NS = 20;
    localparam int unsigned REMOTE_HALF_CYC =
        (REMOTE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOST_ADDR_BITS  = 8;
    localparam int unsigned HOST_FRAME_BITS = 24;
    localparam logic [4:0]  REM_BITS_NARROW = 5'h0010;
    localparam logic [4:0]  REM_BITS_WIDE   = 5'h0018;

    typedef enum logic [2:0] {
        RS_IDLE  = 3'b001,
        RS_SHIFT = 3'b010,
        RS_DONE  = 3'b100
    } remote_state_t;
endpackage

// >>> rtl/host_data_and_passthrough.sv
`timescale 1ns/100ps
module host_data_and_passthrough (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        link_clk,
    input  wire logic        link_sel_n,
    input  wire logic        link_din,
    output logic             link_dout,
    output logic             link_dout_oe,
    output logic             remote_clk,
    output logic             remote_voc_sel_n,
    output logic             remote_trx_sel_n,
    output logic             remote_dout,
    input  wire logic        remote_din,
    output logic [79:0]      tx_words,
    output logic             tx_block_valid,
    input  wire logic        rx_load,
    input  wire logic [71:0] rx_payload,
    input  wire logic [1:0]  rx_block_id,
    input  wire logic [3:0]  rx_byte_count,
    input  wire logic        rx_crc_fail,
    input  wire logic [15:0] rx_status_code,
    input  wire logic        event_irq_en,
    input  wire logic        ready_irq_en,
    output logic             irq,
    output logic [15:0]      mode_value,
    output logic             ps_restart,
    input  wire logic [1:0]  transceiver_variant_word,
    input  wire logic [1:0]  powersave_option_word,
    input  wire logic        energy_sampling,
    input  wire logic        host_low_power,
    input  wire logic [1:0]  host_enhanced,
    input  wire logic [15:0] aux_off_time,
    input  wire logic [15:0] aux_threshold,
    output logic             transceiver_low_power_bit,
    output logic [1:0]       transceiver_enhanced,
    output logic             single_channel,
    output logic [15:0]      ps_off_time,
    output logic [15:0]      ps_threshold
);
    import modem_host_pkg::*;

    // ==========================================
    // Link side: serial frame receive
    logic [4:0]  lbit_q;
    logic [23:0] lsh_q;
    logic [15:0] lrd_q;
    logic        lrd_frame_q;
    logic [23:0] lwr_word_q;
    logic [7:0]  lrd_addr_q;
    logic        lwr_tgl_q, lrd_tgl_q;
    logic [15:0] lcopy_q [READ_WORDS];
    logic        lreq_s1_q, lreq_s2_q, lack_q;
    logic        snap_req_q;
    logic [15:0] snap_q [READ_WORDS];
    logic [2:0]  lidx;
    logic        lhit;
    logic        frame_rst;
    logic [23:0] lsh_nx;

    assign frame_rst = rst | link_sel_n;
    assign lsh_nx    = {lsh_q[22:0], link_din};

    always_comb begin
        lhit = 1'b1;
        unique case (lsh_nx[7:0])
            RX_W0_OFS:    lidx = 3'd0;
            RX_W1_OFS:    lidx = 3'd1;
            RX_W2_OFS:    lidx = 3'd2;
            RX_W3_OFS:    lidx = 3'd3;
            RX_W4_OFS:    lidx = 3'd4;
            STATUS_OFS:   lidx = 3'd5;
            MODEM_ST_OFS: lidx = 3'd6;
            default: begin
                lidx = 3'd0;
                lhit = 1'b0;
            end
        endcase
    end

    // Frame state ends with the select pin itself
    always_ff @(posedge link_clk or posedge frame_rst) begin
        if (frame_rst) begin
            lbit_q      <= 5'h0000;
            lsh_q       <= 24'h0000_00;
            lrd_q       <= 16'h0000;
            lrd_frame_q <= 1'b0;
        end else begin
            if (lbit_q != 5'(HOST_FRAME_BITS))
                lbit_q <= lbit_q + 5'h0001;
            lsh_q <= lsh_nx;
            if (lbit_q == 5'(HOST_ADDR_BITS - 1)) begin
                lrd_frame_q <= lhit;
                lrd_q       <= lhit ? lcopy_q[lidx] : 16'h0000;
            end else begin
                lrd_q <= {lrd_q[14:0], 1'b0};
            end
        end
    end

    assign link_dout    = lrd_q[15];
    assign link_dout_oe = lrd_frame_q & ~link_sel_n;

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lwr_tgl_q  <= 1'b0;
            lrd_tgl_q  <= 1'b0;
            lwr_word_q <= 24'h0000_00;
            lrd_addr_q <= 8'h00;
        end else if (!link_sel_n) begin
            if (lbit_q == 5'(HOST_ADDR_BITS - 1) && lhit) begin
                lrd_addr_q <= lsh_nx[7:0];
                lrd_tgl_q  <= ~lrd_tgl_q;
            end
            if (lbit_q == 5'(HOST_FRAME_BITS - 1) && !lrd_frame_q) begin
                lwr_word_q <= lsh_nx;
                lwr_tgl_q  <= ~lwr_tgl_q;
            end
        end
    end

    // Snapshot handshake receive side
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            lreq_s1_q <= 1'b0;
            lreq_s2_q <= 1'b0;
            lack_q    <= 1'b0;
            for (int i = 0; i < READ_WORDS; i++)
                lcopy_q[i] <= 16'h0000;
        end else begin
            lreq_s1_q <= snap_req_q;
            lreq_s2_q <= lreq_s1_q;
            if (lreq_s2_q != lack_q) begin
                lack_q <= lreq_s2_q;
                for (int i = 0; i < READ_WORDS; i++)
                    lcopy_q[i] <= snap_q[i];
            end
        end
    end

    // ==========================================
    // Crossings into mclk
    logic [2:0] wr_sync_q, rd_sync_q;
    logic       ack_s1_q, ack_s2_q;
    logic       wr_ev, rd_ev;
    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic [15:0] live [READ_WORDS];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_sync_q <= 3'b000;
            rd_sync_q <= 3'b000;
            ack_s1_q  <= 1'b0;
            ack_s2_q  <= 1'b0;
        end else begin
            wr_sync_q <= {wr_sync_q[1:0], lwr_tgl_q};
            rd_sync_q <= {rd_sync_q[1:0], lrd_tgl_q};
            ack_s1_q  <= lack_q;
            ack_s2_q  <= ack_s1_q;
        end
    end

    assign wr_ev   = wr_sync_q[2] ^ wr_sync_q[1];
    assign rd_ev   = rd_sync_q[2] ^ rd_sync_q[1];
    assign wr_addr = lwr_word_q[23:16];
    assign wr_data = lwr_word_q[15:0];

    // Snapshot only moves while the link side has acknowledged
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            snap_req_q <= 1'b0;
            for (int i = 0; i < READ_WORDS; i++)
                snap_q[i] <= 16'h0000;
        end else if (snap_req_q == ack_s2_q) begin
            snap_req_q <= ~snap_req_q;
            for (int i = 0; i < READ_WORDS; i++)
                snap_q[i] <= live[i];
        end
    end

    // ==========================================
    // Transmit block and mode
    logic [15:0] tx_q [5];
    logic [1:0]  tx_cnt_q;
    logic [15:0] mode_q;
    logic        mode_chg;
    logic        tx_new;
    logic        tx_seq_err;

    assign mode_chg   = wr_ev && wr_addr == MODE_OFS && wr_data != mode_q;
    assign tx_new     = wr_ev && wr_addr == TX_W0_OFS
                        && wr_data[TCNT_LSB+:2] != tx_cnt_q;
    assign tx_seq_err = tx_new
                        && wr_data[TCNT_LSB+:2] != tx_cnt_q + 2'd1;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 5; i++)
                tx_q[i] <= 16'h0000;
        end else if (wr_ev) begin
            unique case (wr_addr)
                TX_W0_OFS: tx_q[0] <= wr_data;
                TX_W1_OFS: tx_q[1] <= wr_data;
                TX_W2_OFS: tx_q[2] <= wr_data;
                TX_W3_OFS: tx_q[3] <= wr_data;
                TX_W4_OFS: tx_q[4] <= wr_data;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_cnt_q       <= 2'd0;
            tx_block_valid <= 1'b0;
        end else begin
            tx_block_valid <= tx_new;
            if (mode_chg)
                tx_cnt_q <= 2'd0;
            else if (tx_new)
                tx_cnt_q <= wr_data[TCNT_LSB+:2];
        end
    end

    assign tx_words = {tx_q[4], tx_q[3], tx_q[2], tx_q[1], tx_q[0]};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_q     <= MODE_RESET;
            ps_restart <= 1'b0;
        end else begin
            ps_restart <= wr_ev && wr_addr == MODE_OFS
                          && wr_data[3:0] == MODE_PSAVE
                          && mode_q[3:0] == MODE_PSAVE;
            if (wr_ev && wr_addr == MODE_OFS)
                mode_q <= wr_data;
        end
    end

    assign mode_value = mode_q;

    // ==========================================
    // Pass-through engine
    logic [15:0]   pt_addr_q;
    logic          pflag_q;
    remote_state_t rs_q;
    logic [23:0]   rsh_q;
    logic [15:0]   rin_q;
    logic [4:0]    rcnt_q, rlen_q;
    logic [7:0]    rdiv_q;
    logic          rclk_q, rvoc_q, rrd_q, rwide_q;
    logic [1:0]    din_sync_q;
    logic          pt_go, pt_ok, rtick;

    assign pt_ok = pt_addr_q[11:8] == PT_MARK
                   && !pt_addr_q[PT_RSV_BIT];
    assign pt_go = wr_ev && wr_addr == PROG_DATA_OFS;
    assign rtick = rdiv_q == 8'(REMOTE_HALF_CYC - 1);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            pt_addr_q <= 16'h0000;
        else if (wr_ev && wr_addr == PROG_ADDR_OFS)
            pt_addr_q <= wr_data;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            din_sync_q <= 2'b00;
        else
            din_sync_q <= {din_sync_q[0], remote_din};
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rs_q    <= RS_IDLE;
            rsh_q   <= 24'h0000_00;
            rin_q   <= 16'h0000;
            rcnt_q  <= 5'h0000;
            rlen_q  <= 5'h0000;
            rdiv_q  <= 8'h00;
            rclk_q  <= 1'b0;
            rvoc_q  <= 1'b0;
            rrd_q   <= 1'b0;
            rwide_q <= 1'b0;
        end else begin
            unique case (rs_q)
                RS_IDLE: begin
                    // Transceiver has no read path: read is dropped
                    if (pt_go && pt_ok && !(pt_addr_q[PT_RD_BIT]
                        && !pt_addr_q[PT_SEL_BIT])) begin
                        rs_q    <= RS_SHIFT;
                        rvoc_q  <= pt_addr_q[PT_SEL_BIT];
                        rrd_q   <= pt_addr_q[PT_RD_BIT];
                        rwide_q <= pt_addr_q[PT_WIDE_BIT];
                        rlen_q  <= pt_addr_q[PT_WIDE_BIT] ? REM_BITS_WIDE
                                                          : REM_BITS_NARROW;
                        rsh_q   <= pt_addr_q[PT_WIDE_BIT]
                                   ? {pt_addr_q[7:0], wr_data}
                                   : {pt_addr_q[7:0], wr_data[7:0], 8'h00};
                        rcnt_q  <= 5'h0000;
                        rdiv_q  <= 8'h00;
                        rin_q   <= 16'h0000;
                    end
                end
                RS_SHIFT: begin
                    rdiv_q <= rtick ? 8'h00 : rdiv_q + 8'h01;
                    if (rtick) begin
                        rclk_q <= ~rclk_q;
                        if (!rclk_q) begin
                            rcnt_q <= rcnt_q + 5'h0001;
                            rin_q  <= {rin_q[14:0], din_sync_q[1]};
                        end else begin
                            rsh_q <= {rsh_q[22:0], 1'b0};
                            if (rcnt_q == rlen_q)
                                rs_q <= RS_DONE;
                        end
                    end
                end
                RS_DONE: rs_q <= RS_IDLE;
                default: rs_q <= RS_IDLE;
            endcase
        end
    end

    assign remote_clk       = rclk_q;
    assign remote_dout      = rsh_q[23];
    assign remote_voc_sel_n = ~(rs_q == RS_SHIFT && rvoc_q);
    assign remote_trx_sel_n = ~(rs_q == RS_SHIFT && !rvoc_q);

    // Ready at reset; busy from an accepted programming write to completion, dropped writes leave it ready
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            pflag_q <= 1'b1;
        else if (rs_q == RS_DONE || (pt_go && rs_q == RS_IDLE
                 && !(pt_ok && !(pt_addr_q[PT_RD_BIT]
                 && !pt_addr_q[PT_SEL_BIT]))))
            pflag_q <= 1'b1;
        else if (pt_go)
            pflag_q <= 1'b0;
    end

    // ==========================================
    // Receive block, status and interrupt
    logic [15:0] rx_q [5];
    logic [1:0]  rx_cnt_q;
    logic        event_q, ready_q;
    logic [15:0] modem_st_q;
    logic        st_read;

    assign st_read = rd_ev && lrd_addr_q == STATUS_OFS;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_cnt_q <= 2'd0;
            for (int i = 0; i < 5; i++)
                rx_q[i] <= 16'h0000;
        end else if (mode_chg) begin
            rx_cnt_q <= 2'd0;
        end else if (rx_load) begin
            rx_cnt_q <= rx_cnt_q + 2'd1;
            rx_q[0]  <= {rx_payload[7:0], rx_cnt_q + 2'd1,
                         rx_block_id, rx_byte_count};
            for (int i = 1; i < 5; i++)
                rx_q[i] <= rx_payload[i*16-8+:16];
        end else if (rs_q == RS_DONE && rrd_q) begin
            rx_q[0] <= rwide_q ? rin_q : {8'h00, rin_q[7:0]};
        end
    end

    // Set wins over the clear on status read
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            event_q    <= 1'b0;
            ready_q    <= 1'b0;
            modem_st_q <= 16'h0000;
        end else begin
            if (tx_seq_err || (rx_load && rx_crc_fail))
                event_q <= 1'b1;
            else if (st_read)
                event_q <= 1'b0;
            if (rx_load)
                ready_q <= 1'b1;
            else if (st_read)
                ready_q <= 1'b0;
            if (rx_load && rx_crc_fail)
                modem_st_q <= rx_status_code;
        end
    end

    assign irq = (event_q & event_irq_en) | (ready_q & ready_irq_en);

    always_comb begin
        for (int i = 0; i < 5; i++)
            live[i] = rx_q[i];
        live[5] = 16'h0000;
        live[5][ST_EVENT_BIT] = event_q;
        live[5][ST_READY_BIT] = ready_q;
        live[5][ST_PFLAG_BIT] = pflag_q;
        live[6] = modem_st_q;
    end

    // ==========================================
    // Powersave transceiver controls
    logic sampling_dyn;

    assign sampling_dyn = energy_sampling
                          && powersave_option_word[OPT_DYN_LP];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            transceiver_low_power_bit <= 1'b0;
            transceiver_enhanced      <= 2'b00;
            single_channel            <= 1'b0;
            ps_off_time               <= 16'h0000;
            ps_threshold              <= 16'h0000;
        end else begin
            transceiver_low_power_bit <= sampling_dyn
                                         ? 1'b0 : host_low_power;
            transceiver_enhanced <= (sampling_dyn
                && transceiver_variant_word == VAR_ENH_E)
                ? 2'b00 : host_enhanced;
            single_channel <= energy_sampling
                && powersave_option_word[OPT_SINGLE]
                && transceiver_variant_word != 2'b00;
            ps_off_time  <= aux_off_time;
            ps_threshold <= aux_threshold;
        end
    end

    // ==========================================
    // Checks
    sequence s_pt_start;
        rs_q == RS_IDLE && pt_go && pt_ok && !pt_addr_q[PT_RD_BIT];
    endsequence

    property p_pflag_clear;
        @(posedge mclk) disable iff (rst)
        s_pt_start |=> !pflag_q ##1 rs_q == RS_SHIFT;
    endproperty
    a_pflag_clear: assert property (p_pflag_clear)
        else $error("program flag not cleared on transfer start");

    property p_pflag_done;
        @(posedge mclk) disable iff (rst)
        rs_q == RS_DONE |=> pflag_q;
    endproperty
    a_pflag_done: assert property (p_pflag_done)
        else $error("program flag not set after transfer");

    property p_seq_event;
        @(posedge mclk) disable iff (rst)
        tx_seq_err |=> event_q;
    endproperty
    a_seq_event: assert property (p_seq_event)
        else $error("out of sequence block did not set event");

    property p_tx_valid;
        @(posedge mclk) disable iff (rst)
        tx_block_valid |-> $changed(tx_cnt_q) || $past(mode_chg);
    endproperty
    a_tx_valid: assert property (p_tx_valid)
        else $error("transmit block taken without counter change");

    property p_rx_count;
        @(posedge mclk) disable iff (rst)
        rx_load && !mode_chg |=> rx_cnt_q == $past(rx_cnt_q) + 2'd1
            && rx_q[0][TCNT_LSB+:2] == rx_cnt_q;
    endproperty
    a_rx_count: assert property (p_rx_count)
        else $error("receive counter did not advance");

    property p_mode_clear;
        @(posedge mclk) disable iff (rst)
        mode_chg |=> tx_cnt_q == 2'd0 && rx_cnt_q == 2'd0;
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("counters not cleared on mode change");

    property p_crc_event;
        @(posedge mclk) disable iff (rst)
        rx_load && rx_crc_fail |=> event_q && ready_q
            && modem_st_q == $past(rx_status_code);
    endproperty
    a_crc_event: assert property (p_crc_event)
        else $error("crc failure not flagged");

    property p_trx_no_read;
        @(posedge mclk) disable iff (rst)
        rs_q == RS_SHIFT |-> rvoc_q || !rrd_q;
    endproperty
    a_trx_no_read: assert property (p_trx_no_read)
        else $error("read issued to transceiver");

    property p_lp_drop;
        @(posedge mclk) disable iff (rst)
        sampling_dyn |=> !transceiver_low_power_bit;
    endproperty
    a_lp_drop: assert property (p_lp_drop)
        else $error("low power bit kept during sampling");

    property p_restart;
        @(posedge mclk) disable iff (rst)
        ps_restart |-> mode_q[3:0] == MODE_PSAVE ##1 !ps_restart;
    endproperty
    a_restart: assert property (p_restart)
        else $error("powersave restart malformed");
endmodule

// >>> testbench/remote_model.sv
`timescale 1ns/100ps
// Remote register device on the pass-through serial bus
module remote_model (
    input  wire logic sclk,
    input  wire logic sel_n,
    input  wire logic mosi,
    output logic      miso
);
    logic [23:0] sh;
    logic [7:0]  ra;
    logic [7:0]  last_a = 8'h00;
    logic [15:0] last_d = 16'h0000;
    logic [15:0] mem [128];
    int          n = 0;
    initial miso = 1'b0;
    always @(negedge sel_n) n = 0;
    always @(posedge sclk) begin
        if (!sel_n) begin
            sh = {sh[22:0], mosi};
            n++;
            if (n == 8) ra = sh[7:0];
        end
    end
    always @(negedge sclk) begin
        if (!sel_n && n >= 8 && n < 24) miso = mem[ra[6:0]][23 - n];
    end
    // Released line never keeps its last value
    always @(posedge sel_n) begin
        miso = ~miso;
        if (n == 24) {last_a, last_d} = sh;
        if (n == 16) {last_a, last_d} = {sh[15:8], 8'h00, sh[7:0]};
        if (n >= 16 && !last_a[7]) mem[last_a[6:0]] = last_d;
    end
endmodule

// >>> testbench/host_data_and_passthrough_bench.sv
`timescale 1ns/100ps
module host_data_and_passthrough_bench;
    import modem_host_pkg::*;
    logic mclk = 0, rst = 1, link_clk = 0, link_sel_n = 1, link_din = 0;
    logic rx_load = 0, rx_crc_fail = 0, event_irq_en = 1, ready_irq_en = 0;
    logic energy_sampling = 0, host_low_power = 1;
    logic [71:0] rx_payload = 72'h12_3456_789a_bcde_f0a5;
    logic [1:0]  rx_block_id = 2'h2, transceiver_variant_word = 2'h2;
    logic [1:0]  powersave_option_word = 2'h3, host_enhanced = 2'h3;
    logic [3:0]  rx_byte_count = 4'h9;
    logic [15:0] rx_status_code = 16'h00a3, aux_off_time = 16'h0123;
    logic [15:0] aux_threshold = 16'h0456, mode_value, ps_off_time, r;
    logic [15:0] ps_threshold;
    logic [79:0] tx_words;
    logic [1:0]  transceiver_enhanced;
    logic        link_dout, link_dout_oe, remote_clk, remote_voc_sel_n;
    logic        remote_trx_sel_n, remote_dout, remote_din, tx_block_valid;
    logic        irq, ps_restart, transceiver_low_power_bit, single_channel;
    logic        oe;
    int          n_fail = 0, n_checks = 0, n_txv = 0, n_psr = 0;
    host_data_and_passthrough uut (.*);
    remote_model u_voc (.sclk(remote_clk), .sel_n(remote_voc_sel_n),
        .mosi(remote_dout), .miso(remote_din));
    remote_model u_trx (.sclk(remote_clk), .sel_n(remote_trx_sel_n),
        .mosi(remote_dout), .miso());
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        n_txv += int'(tx_block_valid === 1'b1);
        n_psr += int'(ps_restart === 1'b1);
    end
    task conclude;
        if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // ==========================================
    // Host frame: 8 address bits, 16 data bits, MSB first
    task xf(input logic [7:0] a, input logic [15:0] d);
        logic [23:0] f;
        f = {a, d};
        #1.3 link_sel_n = 0;
        for (int i = 23; i >= 0; i--) begin
            link_din = f[i];
            #6 link_clk = 1;
            #3 if (i >= 1 && i <= 16) r = {r[14:0], link_dout};
            if (i == 1) oe = link_dout_oe;
            #3 link_clk = 0;
        end
        #6 link_sel_n = 1;
        repeat (10) @(posedge mclk);
    endtask
    task rd(input logic [7:0] a, input logic [15:0] m, e, input string nm);
        xf(a, 16'h0000);
        chk(nm, e, r & m);
    endtask
    task waitflag;
        for (int k = 0; k < 40; k++) begin
            xf(8'hc6, 16'h0000);
            if (r[0] === 1'b1) break;
        end
        chk("flag", 16'h0001, {15'h0000, r[0]});
    endtask
    task pt(input logic [15:0] a, d);
        xf(8'hc7, a);
        xf(8'hc8, d);
        waitflag;
    endtask
    task load(input logic crc);
        @(negedge mclk) rx_load = 1;
        rx_crc_fail = crc;
        @(negedge mclk) rx_load = 0;
        rx_crc_fail = 0;
        repeat (6) @(posedge mclk);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk) rst = 0;
        repeat (4) @(posedge mclk);
        rd(8'hc6, 16'h0001, 16'h0001, "flag");
        xf(8'hb6, 16'h1111);
        xf(8'hb5, 16'h0049);
        chk("txv", 16'h0001, 16'(n_txv));
        chk("txw", 16'h1111, tx_words[31:16]);
        chk("oe", 16'h0000, {15'h0000, oe});
        xf(8'hb5, 16'h0049);
        chk("txv", 16'h0001, 16'(n_txv));
        xf(8'hb5, 16'h00c9);
        chk("txw0", 16'h00c9, tx_words[15:0]);
        chk("irq", 16'h0001, {15'h0000, irq});
        rd(8'hc6, 16'h4000, 16'h4000, "event");
        load(0);
        rd(8'hb8, 16'hffff, 16'ha569, "rx0");
        chk("oe", 16'h0001, {15'h0000, oe});
        rd(8'hb9, 16'hffff, 16'hdef0, "rx1");
        rd(8'hc5, 16'hffff, 16'h1234, "rx4");
        load(1);
        rd(8'hc6, 16'h4040, 16'h4040, "crc");
        rd(8'hc9, 16'hffff, 16'h00a3, "code");
        rd(8'hb8, 16'hffff, 16'ha5a9, "rx0");
        xf(8'hc1, 16'h0009);
        xf(8'hc1, 16'h0009);
        chk("restart", 16'h0001, 16'(n_psr));
        chk("mode", 16'h0009, mode_value);
        load(0);
        rd(8'hb8, 16'hffff, 16'ha569, "rx0");
        @(negedge mclk) energy_sampling = 1;
        repeat (3) @(posedge mclk);
        chk("psv", 16'h0001, {13'h0000, transceiver_low_power_bit,
            transceiver_enhanced, single_channel});
        @(negedge mclk) energy_sampling = 0;
        repeat (3) @(posedge mclk);
        chk("psv", 16'h0007, {13'h0000, transceiver_low_power_bit,
            transceiver_enhanced});
        chk("off", aux_off_time, ps_off_time);
        chk("thr", aux_threshold, ps_threshold);
        xf(8'hc1, 16'h0000);
        waitflag;
        xf(8'hc7, 16'h6f12);
        xf(8'hc8, 16'habcd);
        rd(8'hc6, 16'h0001, 16'h0000, "busy");
        waitflag;
        chk("voc", 16'habcd, u_voc.last_d);
        pt(16'hef92, 16'h0000);
        rd(8'hb8, 16'hffff, 16'habcd, "vrd");
        pt(16'h2f34, 16'h1256);
        chk("voc8", 16'h3456, {u_voc.last_a, u_voc.last_d[7:0]});
        pt(16'h0f11, 16'h0077);
        chk("trx", 16'h1177, {u_trx.last_a, u_trx.last_d[7:0]});
        pt(16'h4f17, 16'h7abc);
        chk("trx16", 16'h7abc, u_trx.last_d);
        pt(16'h8f11, 16'h0000);
        chk("trxrd", 16'h0017, {8'h00, u_trx.last_a});
        pt(16'h6e12, 16'h5555);
        chk("mark", 16'h0034, {8'h00, u_voc.last_a});
        conclude;
    end
    initial begin
        #200000;
        n_fail++;
        conclude;
    end
endmodule
